// ===== cbr_consts.svh
// Offsets, field positions, reset values and sizes of the configurable block RAM
`ifndef CBR_CONSTS_SVH
`define CBR_CONSTS_SVH
`define CBR_CTRL_OFF 12'h000
`define CBR_SHIFT_OFF 12'h004
`define CBR_STAT_OFF 12'h008
`define CBR_F_OPMODE 0
`define CBR_F_CLKMODE 4
`define CBR_F_WIDTHA 8
`define CBR_F_WIDTHB 12
`define CBR_F_OUTREGA 16
`define CBR_F_RDWNEW 18
`define CBR_F_ROMLOAD 19
`define CBR_F_MAXDEPTH 24
`define CBR_F_TAPLEN 0
`define CBR_F_TAPW 8
`define CBR_F_TAPN 16
`define CBR_F_PTR 8
`define CBR_CTRL_RST 32'h0d00_0000
`define CBR_CTRL_MASK 32'h0f0f_ff37
`define CBR_SHIFT_RST 32'h0001_0100
`define CBR_SHIFT_MASK 32'h003f_3fff
`define CBR_BLOCK_BITS 21'h002400
`define CBR_MAX_WIDTH 12'h024
`define CBR_DEPTH_MIN 4'h8
`define CBR_DEPTH_MAX 4'hd
`define CBR_ROWS 256
`endif

// ===== cbr_pkg.sv
// Types shared by the configurable block RAM files
package cbr_pkg;
  // Operation modes
  typedef enum logic [2:0] {
    OP_SP_RAM = 3'h0, OP_SDP_RAM = 3'h1, OP_TDP_RAM = 3'h2, OP_SP_ROM = 3'h3,
    OP_DP_ROM = 3'h4, OP_SHIFT = 3'h5, OP_FIFO = 3'h6
  } cbr_op_t;
  // Clocking schemes
  typedef enum logic [1:0] {
    CK_SINGLE = 2'h0, CK_INDEP = 2'h1, CK_INOUT = 2'h2, CK_RDWR = 2'h3
  } cbr_clk_t;
  // Port shapes, narrowest first
  typedef enum logic [3:0] {
    W1 = 4'h0, W2 = 4'h1, W4 = 4'h2, W8 = 4'h3, W9 = 4'h4,
    W16 = 4'h5, W18 = 4'h6, W32 = 4'h7, W36 = 4'h8
  } cbr_width_t;
endpackage : cbr_pkg

// ===== cbr_mem.sv
// Storage array of 256 rows by 36 bits with two bit-masked ports
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_mem (
  // Clock
  input wire logic clk,
  // Port A
  input wire logic aEn,
  input wire logic aWe,
  input wire logic [7:0] aRow,
  input wire logic [35:0] aWdata,
  input wire logic [35:0] aWmask,
  output logic [35:0] aRdata,
  // Port B
  input wire logic bEn,
  input wire logic bWe,
  input wire logic [7:0] bRow,
  input wire logic [35:0] bWdata,
  input wire logic [35:0] bWmask,
  output logic [35:0] bRdata
);
  logic [35:0] mem [`CBR_ROWS];

  // Reads see the row before this edge's writes; B lands last on a clash
  always_ff @(posedge clk) begin
    for (int i = 0; i < 36; i++) begin
      if (aWe && aWmask[i]) mem[aRow][i] <= aWdata[i];
      if (bWe && bWmask[i]) mem[bRow][i] <= bWdata[i];
    end
    if (aEn) aRdata <= mem[aRow];
    if (bEn) bRdata <= mem[bRow];
  end
endmodule : cbr_mem

// ===== cbr_block.sv
// Configurable 9 Kbit block RAM with APB configuration and two user ports
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_block (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port A
  input wire logic [12:0] aAddr,
  input wire logic [35:0] aData,
  input wire logic [3:0] aByteEn,
  input wire logic aWrEn,
  input wire logic aRdEn,
  input wire logic aAddrHold,
  input wire logic aCe,
  input wire logic aClr,
  output logic [35:0] aQ,
  // Port B
  input wire logic [12:0] bAddr,
  input wire logic [35:0] bData,
  input wire logic [3:0] bByteEn,
  input wire logic bWrEn,
  input wire logic bRdEn,
  input wire logic bAddrHold,
  input wire logic bCe,
  input wire logic bClr,
  output logic [35:0] bQ
);
  // Address bits per shape
  function automatic logic [3:0] depthLog(input cbr_pkg::cbr_width_t w);
    case (w)
      cbr_pkg::W1: depthLog = 4'hd;
      cbr_pkg::W2: depthLog = 4'hc;
      cbr_pkg::W4: depthLog = 4'hb;
      cbr_pkg::W8, cbr_pkg::W9: depthLog = 4'ha;
      cbr_pkg::W16, cbr_pkg::W18: depthLog = 4'h9;
      default: depthLog = 4'h8;
    endcase
  endfunction : depthLog

  // Data bits per shape
  function automatic logic [5:0] widthBits(input cbr_pkg::cbr_width_t w);
    case (w)
      cbr_pkg::W1: widthBits = 6'h01;
      cbr_pkg::W2: widthBits = 6'h02;
      cbr_pkg::W4: widthBits = 6'h04;
      cbr_pkg::W8: widthBits = 6'h08;
      cbr_pkg::W9: widthBits = 6'h09;
      cbr_pkg::W16: widthBits = 6'h10;
      cbr_pkg::W18: widthBits = 6'h12;
      cbr_pkg::W32: widthBits = 6'h20;
      default: widthBits = 6'h24;
    endcase
  endfunction : widthBits

  // Shapes that use the ninth bit of every lane
  function automatic logic isPar(input cbr_pkg::cbr_width_t w);
    isPar = (w == cbr_pkg::W9) || (w == cbr_pkg::W18) || (w == cbr_pkg::W36);
  endfunction : isPar

  // Logical row bit to physical bit; power-of-two shapes skip each ninth bit
  function automatic logic [5:0] physOf(input cbr_pkg::cbr_width_t w, input logic [5:0] lb);
    physOf = isPar(w) ? lb : lb + {3'h0, lb[5:3]};
  endfunction : physOf

  // Row holding a word
  function automatic logic [7:0] rowOf(input cbr_pkg::cbr_width_t w, input logic [12:0] a);
    logic [12:0] r;
    r = a >> (depthLog(w) - 4'h8);
    rowOf = r[7:0];
  endfunction : rowOf

  // First logical bit of a word inside its row
  function automatic logic [5:0] baseOf(input cbr_pkg::cbr_width_t w, input logic [12:0] a);
    logic [12:0] m;
    logic [12:0] p;
    m = (13'h1 << (depthLog(w) - 4'h8)) - 13'h1;
    p = (a & m) * {7'h0, widthBits(w)};
    baseOf = p[5:0];
  endfunction : baseOf

  // Places a word into a row as {mask, data}
  function automatic logic [71:0] place(input cbr_pkg::cbr_width_t w, input logic [12:0] a,
                                        input logic [35:0] d, input logic [3:0] be);
    logic [35:0] m;
    logic [35:0] v;
    logic [5:0] p;
    logic [1:0] ln;
    m = '0;
    v = '0;
    for (int i = 0; i < 36; i++) begin
      if (6'(i) < widthBits(w)) begin
        p = physOf(w, baseOf(w, a) + 6'(i));
        ln = isPar(w) ? 2'(i / 9) : 2'(i / 8);
        m[p] = (widthBits(w) < 6'h10) ? 1'b1 : be[ln];
        v[p] = d[i];
      end
    end
    place = {m, v};
  endfunction : place

  // Pulls a word out of a row, upper bits zero
  function automatic logic [35:0] extract(input cbr_pkg::cbr_width_t w, input logic [12:0] a,
                                          input logic [35:0] row);
    logic [35:0] q;
    q = '0;
    for (int i = 0; i < 36; i++) begin
      if (6'(i) < widthBits(w)) q[i] = row[physOf(w, baseOf(w, a) + 6'(i))];
    end
    extract = q;
  endfunction : extract

  logic [31:0] ctrl_r;
  logic [31:0] shift_r;
  logic cfgOk_r;
  logic cfgOk_nxt;
  logic [7:0] shPtr_r;
  logic [31:0] rdMux;
  logic mapped;
  cbr_pkg::cbr_op_t opMode;
  cbr_pkg::cbr_clk_t clkMode;
  cbr_pkg::cbr_width_t wid [2];
  logic [3:0] maxDepth;
  logic shiftMode;
  logic rdwNew;
  logic ceIn [2];
  logic ceOut [2];
  logic wrOk [2];
  logic rdOk [2];
  logic [12:0] adIn [2];
  logic [35:0] dIn [2];
  logic [3:0] beIn [2];
  logic wrIn [2];
  logic rdIn [2];
  logic holdIn [2];
  logic clrIn [2];
  logic memEn [2];
  logic memWe [2];
  logic [7:0] memRow [2];
  logic [35:0] memWd [2];
  logic [35:0] memWm [2];
  logic [35:0] memRd [2];
  logic [35:0] qOut [2];

  // User ports gathered per port index, A first
  assign adIn = '{aAddr, bAddr};
  assign dIn = '{aData, bData};
  assign beIn = '{aByteEn, bByteEn};
  assign wrIn = '{aWrEn, bWrEn};
  assign rdIn = '{aRdEn, bRdEn};
  assign holdIn = '{aAddrHold, bAddrHold};
  assign clrIn = '{aClr, bClr};
  assign aQ = qOut[0];
  assign bQ = qOut[1];

  // Configuration fields; illegal codes fall out through the legality check
  assign opMode = cbr_pkg::cbr_op_t'(ctrl_r[`CBR_F_OPMODE +: 3]);
  assign clkMode = cbr_pkg::cbr_clk_t'(ctrl_r[`CBR_F_CLKMODE +: 2]);
  assign maxDepth = ctrl_r[`CBR_F_MAXDEPTH +: 4];
  assign rdwNew = ctrl_r[`CBR_F_RDWNEW];
  assign shiftMode = (opMode == cbr_pkg::OP_SHIFT);
  // Each port takes its own width field in every mode; single-port modes still check port B's depth
  assign wid[0] = cbr_pkg::cbr_width_t'(ctrl_r[`CBR_F_WIDTHA +: 4]);
  assign wid[1] = cbr_pkg::cbr_width_t'(ctrl_r[`CBR_F_WIDTHB +: 4]);

  // Legality of the programmed shape; an illegal one freezes the array
  always_comb begin
    logic okW;
    logic okC;
    logic okD;
    logic okS;
    logic grp;
    logic [11:0] wn;
    logic [20:0] bits;
    okW = 1'b0;
    okC = 1'b0;
    grp = (isPar(wid[0]) == isPar(wid[1])) && (wid[0] <= cbr_pkg::W36)
          && (wid[1] <= cbr_pkg::W36);
    case (opMode)
      cbr_pkg::OP_SP_RAM, cbr_pkg::OP_SP_ROM: okW = wid[0] <= cbr_pkg::W36;
      cbr_pkg::OP_SDP_RAM, cbr_pkg::OP_FIFO, cbr_pkg::OP_DP_ROM: okW = grp;
      cbr_pkg::OP_TDP_RAM: okW = grp && wid[0] <= cbr_pkg::W18
                                 && wid[1] <= cbr_pkg::W18;
      cbr_pkg::OP_SHIFT: okW = 1'b1;
      default: okW = 1'b0;
    endcase
    // Clock schemes offered per operation mode
    unique case (clkMode)
      cbr_pkg::CK_SINGLE: okC = 1'b1;
      cbr_pkg::CK_INDEP: okC = opMode == cbr_pkg::OP_TDP_RAM || opMode == cbr_pkg::OP_SP_ROM
                              || opMode == cbr_pkg::OP_DP_ROM;
      cbr_pkg::CK_INOUT: okC = opMode <= cbr_pkg::OP_DP_ROM;
      cbr_pkg::CK_RDWR: okC = opMode == cbr_pkg::OP_SDP_RAM
                             || opMode == cbr_pkg::OP_FIFO;
    endcase
    okD = maxDepth >= `CBR_DEPTH_MIN && maxDepth <= `CBR_DEPTH_MAX
          && (shiftMode || (depthLog(wid[0]) <= maxDepth
          && depthLog(wid[1]) <= maxDepth));
    wn = 12'(shift_r[`CBR_F_TAPW +: 6] * shift_r[`CBR_F_TAPN +: 6]);
    bits = 21'(wn * ({1'b0, shift_r[`CBR_F_TAPLEN +: 8]} + 9'h001));
    okS = !shiftMode || (wn != 12'h000 && wn <= `CBR_MAX_WIDTH
          && bits <= `CBR_BLOCK_BITS);
    cfgOk_nxt = okW && okC && okD && okS;
  end

  // Per-port clock enables stand in for the separate clocks of each scheme
  always_comb begin
    unique case (clkMode)
      cbr_pkg::CK_SINGLE: begin
        ceIn = '{aCe, aCe};
        ceOut = '{aCe, aCe};
      end
      cbr_pkg::CK_INDEP: begin
        ceIn = '{aCe, bCe};
        ceOut = '{aCe, bCe};
      end
      cbr_pkg::CK_INOUT: begin
        ceIn = '{aCe, aCe};
        ceOut = '{bCe, bCe};
      end
      cbr_pkg::CK_RDWR: begin
        ceIn = '{aCe, bCe};
        ceOut = '{bCe, bCe};
      end
    endcase
  end

  // Which port may write or read in each operation mode
  always_comb begin
    unique case (opMode)
      cbr_pkg::OP_SP_RAM: begin
        wrOk = '{1'b1, 1'b0};
        rdOk = '{1'b1, 1'b0};
      end
      cbr_pkg::OP_SDP_RAM, cbr_pkg::OP_FIFO: begin
        wrOk = '{1'b1, 1'b0};
        rdOk = '{1'b0, 1'b1};
      end
      cbr_pkg::OP_TDP_RAM: begin
        wrOk = '{1'b1, 1'b1};
        rdOk = '{1'b1, 1'b1};
      end
      cbr_pkg::OP_SP_ROM, cbr_pkg::OP_DP_ROM: begin
        wrOk = '{ctrl_r[`CBR_F_ROMLOAD], 1'b0};
        rdOk = '{1'b1, opMode == cbr_pkg::OP_DP_ROM};
      end
      default: begin // Shift mode reads through its write path
        wrOk = '{shiftMode, 1'b0};
        rdOk = '{1'b0, 1'b0};
      end
    endcase
    wrOk = '{wrOk[0] && cfgOk_r, wrOk[1] && cfgOk_r};
    rdOk = '{rdOk[0] && cfgOk_r, rdOk[1] && cfgOk_r};
  end

  genvar gp;
  for (gp = 0; gp < 2; gp++) begin : g_port
    logic [12:0] addrR_r;
    logic [35:0] dataR_r;
    logic [3:0] beR_r;
    logic weR_r;
    logic reR_r;
    logic [12:0] addrS_r;
    logic rdV_r;
    logic fwd_r;
    logic [35:0] wdS_r;
    logic [35:0] wmS_r;
    logic [35:0] qLat_r;
    logic [35:0] q_r;
    logic [71:0] placed;
    logic [35:0] rowV;
    logic [35:0] view;

    // Input registers; a disabled edge leaves no operation pending
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        addrR_r <= '0;
        dataR_r <= '0;
        beR_r <= '0;
        weR_r <= 1'b0;
        reR_r <= 1'b0;
      end else begin
        if (ceIn[gp] && !holdIn[gp]) addrR_r <= adIn[gp];
        if (ceIn[gp]) begin
          dataR_r <= dIn[gp];
          beR_r <= beIn[gp];
        end
        weR_r <= ceIn[gp] && wrIn[gp] && wrOk[gp];
        reR_r <= ceIn[gp] && rdIn[gp] && rdOk[gp];
      end
    end

    // Array access; shift mode cycles port A through the tap rows
    assign placed = place(wid[gp], addrR_r, dataR_r, beR_r);
    assign memRow[gp] = (shiftMode && gp == 0) ? shPtr_r : rowOf(wid[gp], addrR_r);
    assign memWd[gp] = shiftMode ? dataR_r : placed[35:0];
    assign memWm[gp] = shiftMode ? '1 : placed[71:36];
    assign memWe[gp] = weR_r;
    assign memEn[gp] = reR_r || (shiftMode && weR_r);

    // Access-stage record for forwarding and word selection
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        addrS_r <= '0;
        rdV_r <= 1'b0;
        fwd_r <= 1'b0;
        wdS_r <= '0;
        wmS_r <= '0;
      end else begin
        if (memEn[gp]) addrS_r <= addrR_r;
        rdV_r <= memEn[gp];
        // Same-port new data only; other ports and read/write mode see old data
        fwd_r <= reR_r && weR_r && rdwNew && !shiftMode
                 && clkMode != cbr_pkg::CK_RDWR;
        wdS_r <= memWd[gp];
        wmS_r <= memWm[gp];
      end
    end

    assign rowV = fwd_r ? ((memRd[gp] & ~wmS_r) | (wdS_r & wmS_r)) : memRd[gp];
    assign view = shiftMode ? rowV : extract(wid[gp], addrS_r, rowV);

    // Output latch and register; only these answer the port clear
    always_ff @(posedge clk or negedge rst_b or posedge clrIn[gp]) begin
      if (!rst_b) begin
        qLat_r <= '0;
        q_r <= '0;
      end else if (clrIn[gp]) begin
        qLat_r <= '0;
        q_r <= '0;
      end else if (ceOut[gp]) begin
        if (rdV_r) qLat_r <= view;
        if (ctrl_r[`CBR_F_OUTREGA + gp]) q_r <= qLat_r;
        else if (rdV_r) q_r <= view;
      end
    end
    assign qOut[gp] = q_r;
  end

  cbr_mem u_mem (
    .clk(clk),
    .aEn(memEn[0]),
    .aWe(memWe[0]),
    .aRow(memRow[0]),
    .aWdata(memWd[0]),
    .aWmask(memWm[0]),
    .aRdata(memRd[0]),
    .bEn(memEn[1]),
    .bWe(memWe[1]),
    .bRow(memRow[1]),
    .bWdata(memWd[1]),
    .bWmask(memWm[1]),
    .bRdata(memRd[1])
  );

  // Tap pointer wraps after tap length plus one rows, giving that many shifts of delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shPtr_r <= '0;
    end else if (!shiftMode) begin
      shPtr_r <= '0;
    end else if (g_port[0].weR_r) begin
      shPtr_r <= (shPtr_r == shift_r[`CBR_F_TAPLEN +: 8]) ? 8'h00 : shPtr_r + 8'h01;
    end
  end

  // Legality is registered so the array sees a settled decision
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cfgOk_r <= 1'b1;
    else cfgOk_r <= cfgOk_nxt;
  end

  // Register read decode
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `CBR_CTRL_OFF: rdMux = ctrl_r;
      `CBR_SHIFT_OFF: rdMux = shift_r;
      `CBR_STAT_OFF: rdMux = {16'h0000, shPtr_r, 7'h00, !cfgOk_r};
      default: begin
        rdMux = '0;
        mapped = 1'b0;
      end
    endcase
  end

  // APB: one wait-free access phase; answer prepared during setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= !mapped;
      end
    end
  end

  // Register writes at the access edge; reserved bits stay zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `CBR_CTRL_RST;
      shift_r <= `CBR_SHIFT_RST;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == `CBR_CTRL_OFF) ctrl_r <= pwdata & `CBR_CTRL_MASK;
      if (paddr == `CBR_SHIFT_OFF) shift_r <= pwdata & `CBR_SHIFT_MASK;
    end
  end
endmodule : cbr_block

// ===== cbr_block_chk.sv
// Port-level assertion checker for the configurable block RAM
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_block_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Port A
  input wire logic aWrEn,
  input wire logic aRdEn,
  input wire logic aClr,
  input wire logic [35:0] aQ,
  // Port B
  input wire logic bRdEn,
  input wire logic bClr,
  input wire logic [35:0] bQ
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Reply one cycle after setup, then gone
  property p_apb_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  // Ready only inside an access phase
  property p_apb_acc;
    pready |-> psel && penable;
  endproperty
  // Error flag marks exactly the unmapped offsets
  property p_apb_err;
    pready |-> pslverr == !(paddr == `CBR_CTRL_OFF || paddr == `CBR_SHIFT_OFF
      || paddr == `CBR_STAT_OFF);
  endproperty
  // Outputs come out of reset cleared
  property p_rst_out;
    $rose(rst_b) |-> aQ == 36'h0 && bQ == 36'h0 && !pready;
  endproperty
  // Without a read or shift two or three edges back, output holds
  property p_aq_hold;
    !$past(aRdEn, 2) && !$past(aRdEn, 3) && !$past(aWrEn, 2) && !$past(aWrEn, 3)
      && !aClr && !$past(aClr) |-> $stable(aQ);
  endproperty
  property p_bq_hold;
    !$past(bRdEn, 2) && !$past(bRdEn, 3) && !bClr && !$past(bClr) |-> $stable(bQ);
  endproperty
  // Clear forces the output to zero at once
  property p_aclr;
    aClr |-> aQ == 36'h0;
  endproperty
  property p_bclr;
    bClr |-> bQ == 36'h0;
  endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("ready timing wrong");
  a_apb_acc: assert property (p_apb_acc) else $error("ready outside access");
  a_apb_err: assert property (p_apb_err) else $error("error flag wrong");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_aq_hold: assert property (p_aq_hold) else $error("aQ moved without read");
  a_bq_hold: assert property (p_bq_hold) else $error("bQ moved without read");
  a_aclr: assert property (p_aclr) else $error("aQ not cleared");
  a_bclr: assert property (p_bclr) else $error("bQ not cleared");
  // A read result shows on the third edge after the request
  c_rd: cover property (aRdEn ##3 $changed(aQ));
  c_clr: cover property (aClr);
  c_err: cover property (pready && pslverr);
endmodule : cbr_block_chk

bind cbr_block cbr_block_chk chk (.clk, .rst_b, .paddr, .psel, .penable, .pready,
  .pslverr, .aWrEn, .aRdEn, .aClr, .aQ, .bRdEn, .bClr, .bQ);

// ===== cbr_user_model.sv
// Behavioural fabric logic that issues requests on both RAM ports
`timescale 1ns/1ps
module cbr_user_model (
  // Port A requests
  output logic [12:0] aAddr,
  output logic [35:0] aData,
  output logic [3:0] aByteEn,
  output logic aWrEn,
  output logic aRdEn,
  // Port B requests
  output logic [12:0] bAddr,
  output logic [35:0] bData,
  output logic [3:0] bByteEn,
  output logic bWrEn,
  output logic bRdEn
);
  // Mirror of the pending port A write, for conflict screening
  logic aWeNxt = 1'b0;
  logic [12:0] aAdNxt = 13'h0;
  // Words written minus words read, as if the array served as a FIFO
  int fifoLvl = 0;

  // Quiet ports at time zero
  initial begin
    {aAddr, aData, aByteEn, aWrEn, aRdEn} = '0;
    {bAddr, bData, bByteEn, bWrEn, bRdEn} = '0;
  end

  // Port A request; idle data lines flip so stale values never pass
  task automatic setA(input logic we, re, input logic [12:0] ad, input logic [35:0] d,
                      input logic [3:0] be);
    aWeNxt = we;
    aAdNxt = ad;
    if (we) fifoLvl++;
    aWrEn <= we;
    aRdEn <= re;
    aAddr <= ad;
    aData <= we ? d : ~aData;
    aByteEn <= be;
  endtask : setA

  // Port B request; call after setA when both ports move together
  task automatic setB(input logic we, re, input logic [12:0] ad, input logic [35:0] d,
                      input logic [3:0] be);
    bWrEn <= we && !(aWeNxt && aAdNxt == ad);
    // A FIFO that held nothing before this write is not read with it
    bRdEn <= re && !(aWeNxt && fifoLvl == 1);
    if (re && fifoLvl > 0) fifoLvl--;
    bAddr <= ad;
    bData <= we ? d : ~bData;
    bByteEn <= be;
  endtask : setB
endmodule : cbr_user_model

// ===== cbr_block_tb_top.sv
// Self-checking testbench for the configurable block RAM
`timescale 1ns/1ps
`include "cbr_consts.svh"
module cbr_block_tb_top;
  typedef struct {logic [12:0] a; logic [35:0] d; logic [3:0] be; logic [35:0] e;} cbr_row_t;
  typedef struct {logic [31:0] ctrl; logic [31:0] shf; logic bad;} cbr_cfg_t;
  // Clock, reset, APB
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  // User ports
  logic aAddrHold = 1'b0, aCe = 1'b1, aClr = 1'b0, bClr = 1'b0;
  logic bAddrHold = 1'b0, bCe = 1'b1;
  logic aWrEn, aRdEn, bWrEn, bRdEn;
  logic [12:0] aAddr, bAddr;
  logic [35:0] aData, bData, aQ, bQ;
  logic [3:0] aByteEn, bByteEn;
  int fails = 0, numChecks = 0, cyc = 0;
  // Write then read back, single-port x36
  cbr_row_t rows [6] = '{'{13'h5, 36'h1_2345_6789, 4'hf, 36'h1_2345_6789},
    '{13'h5, 36'hf_ffff_ffff, 4'h1, 36'h1_2345_67ff},
    '{13'h5, 36'h0, 4'h8, 36'h0_0345_67ff},
    '{13'hff, 36'ha_5a5a_5a5a, 4'hf, 36'ha_5a5a_5a5a},
    '{13'h0, 36'h5_5555_5555, 4'hf, 36'h5_5555_5555},
    '{13'h0, 36'hf_ffff_ffff, 4'h6, 36'h5_57ff_ff55}};
  // Configurations and whether they must be flagged; last one stays
  cbr_cfg_t cfgs [12] = '{'{32'h0d00_8701, `CBR_SHIFT_RST, 1'b1},
    '{32'h0d00_6602, `CBR_SHIFT_RST, 1'b0}, '{32'h0d00_7702, `CBR_SHIFT_RST, 1'b1},
    '{32'h0d00_8830, `CBR_SHIFT_RST, 1'b1}, '{32'h0d00_8831, `CBR_SHIFT_RST, 1'b0},
    '{32'h0d00_5512, `CBR_SHIFT_RST, 1'b0}, '{32'h0d00_8811, `CBR_SHIFT_RST, 1'b1},
    '{32'h0800_0000, `CBR_SHIFT_RST, 1'b1}, '{32'h0900_6600, `CBR_SHIFT_RST, 1'b0},
    '{32'h0d00_8805, 32'h0005_0900, 1'b1}, '{32'h0d00_8805, 32'h0004_0900, 1'b0},
    '{32'h0d00_8800, `CBR_SHIFT_RST, 1'b0}};

  always #25 clk = ~clk;

  cbr_block DUT (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .aAddr, .aData, .aByteEn, .aWrEn, .aRdEn, .aAddrHold, .aCe,
    .aClr, .aQ, .bAddr, .bData, .bByteEn, .bWrEn, .bRdEn, .bAddrHold,
    .bCe, .bClr, .bQ);
  cbr_user_model m (.aAddr, .aData, .aByteEn, .aWrEn, .aRdEn, .bAddr, .bData,
    .bByteEn, .bWrEn, .bRdEn);

  task automatic chk(input string n, input logic [35:0] e, g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("Checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // One APB transfer; the leading edge keeps back-to-back calls apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Read on one port; the result is due two edges after it is taken
  task automatic rd(input logic p, input logic [12:0] ad, input logic [35:0] e);
    if (p) m.setB(1'b0, 1'b1, ad, 36'h0, 4'h0);
    else m.setA(1'b0, 1'b1, ad, 36'h0, 4'h0);
    @(posedge clk);
    if (p) m.setB(1'b0, 1'b0, ad, 36'h0, 4'h0);
    else m.setA(1'b0, 1'b0, ad, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk(p ? "bQ" : "aQ", e, p ? bQ : aQ);
  endtask : rd

  // One enabled edge of a port A request, then idle and wait for output
  task automatic opA(input logic we, re, input logic [35:0] d);
    m.setA(we, re, 13'h5, d, 4'hf);
    @(posedge clk);
    m.setA(1'b0, 1'b0, 13'h5, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
  endtask : opA

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    foreach (cfgs[i]) begin
      apb(1'b1, `CBR_SHIFT_OFF, cfgs[i].shf);
      apb(1'b1, `CBR_CTRL_OFF, cfgs[i].ctrl);
      apb(1'b0, `CBR_STAT_OFF, 32'h0);
      chk("illegal", {35'h0, cfgs[i].bad}, {35'h0, rdat[0]});
    end
    foreach (rows[i]) begin
      m.setA(1'b1, 1'b0, rows[i].a, rows[i].d, rows[i].be);
      @(posedge clk);
      rd(1'b0, rows[i].a, rows[i].e);
    end
    rd(1'b1, 13'h5, 36'h0);
    opA(1'b1, 1'b0, 36'ha);
    chk("aQ", 36'h5_57ff_ff55, aQ);
    opA(1'b1, 1'b1, 36'hb);
    chk("aQ", 36'ha, aQ);
    // Clear hits the output only, stored word survives
    aClr <= 1'b1;
    @(posedge clk);
    chk("aQ", 36'h0, aQ);
    aClr <= 1'b0;
    rd(1'b0, 13'h5, 36'hb);
    aAddrHold <= 1'b1;
    rd(1'b0, 13'h0, 36'hb);
    aAddrHold <= 1'b0;
    // Write with the clock enable low must not land
    aCe <= 1'b0;
    m.setA(1'b1, 1'b0, 13'h5, 36'hc, 4'hf);
    repeat (2) @(posedge clk);
    aCe <= 1'b1;
    rd(1'b0, 13'h5, 36'hb);
    // Simple dual-port: write A and read B on one row together
    apb(1'b1, `CBR_CTRL_OFF, 32'h0d00_8801);
    m.setA(1'b1, 1'b0, 13'h5, 36'hd, 4'hf);
    m.setB(1'b0, 1'b1, 13'h5, 36'h0, 4'h0);
    @(posedge clk);
    m.setA(1'b0, 1'b0, 13'h5, 36'h0, 4'h0);
    m.setB(1'b0, 1'b0, 13'h5, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk("bQ", 36'hb, bQ);
    rd(1'b1, 13'h5, 36'hd);
    bClr <= 1'b1;
    @(posedge clk);
    chk("bQ", 36'h0, bQ);
    bClr <= 1'b0;
    // Same-port new-data mode passes the word being written
    apb(1'b1, `CBR_CTRL_OFF, 32'h0d04_8800);
    opA(1'b1, 1'b1, 36'he);
    chk("aQ", 36'he, aQ);
    // Shift two rows deep: the third shift hands back the first word
    apb(1'b1, `CBR_SHIFT_OFF, 32'h0004_0901);
    apb(1'b1, `CBR_CTRL_OFF, 32'h0d00_8805);
    m.setA(1'b1, 1'b0, 13'h0, 36'h1_1111_1111, 4'hf);
    @(posedge clk);
    m.setA(1'b1, 1'b0, 13'h0, 36'h2_2222_2222, 4'hf);
    @(posedge clk);
    m.setA(1'b1, 1'b0, 13'h0, 36'h3_3333_3333, 4'hf);
    @(posedge clk);
    m.setA(1'b0, 1'b0, 13'h0, 36'h0, 4'h0);
    repeat (3) @(posedge clk);
    chk("aQ", 36'h1_1111_1111, aQ);
    apb(1'b0, `CBR_STAT_OFF, 32'h0);
    chk("ptr", 36'h1, {28'h0, rdat[15:8]});
    // Reset in mid-run restores outputs and registers
    rst_b <= 1'b0;
    @(posedge clk);
    chk("aQ", 36'h0, aQ);
    rst_b <= 1'b1;
    apb(1'b0, `CBR_CTRL_OFF, 32'h0);
    chk("ctrl", {4'h0, `CBR_CTRL_RST}, {4'h0, rdat});
    apb(1'b0, `CBR_SHIFT_OFF, 32'h0);
    chk("shift", {4'h0, `CBR_SHIFT_RST}, {4'h0, rdat});
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk("pslverr", 36'h1, {35'h0, rerr});
    final_report();
  end
endmodule : cbr_block_tb_top
